// *** pkg/uart_rx_pkg.sv ***
/*
 * shared constants and types for the asynchronous receive recovery block.
 * assumes a single system clock and a baud divisor supplied by the integrator.
 */
package uart_rx_pkg;

    // ------------------------------------------------------------
    // sampling
    // ------------------------------------------------------------
    localparam int unsigned SAMP_NORMAL   = 16;
    localparam int unsigned SAMP_DOUBLE   = 8;
    localparam logic [3:0]  VOTE_N_FIRST  = 4'h8;
    localparam logic [3:0]  VOTE_D_FIRST  = 4'h4;
    localparam logic [3:0]  VOTE_D_REARM  = 4'h7;
    localparam logic [3:0]  BITS_MIN      = 4'h5;
    localparam logic [3:0]  BITS_MAX      = 4'hA;
    localparam int unsigned DIV_W         = 12;
    localparam int unsigned DATA_W        = 10;
    localparam int unsigned FIFO_DEPTH    = 4;
    localparam logic [DATA_W-1:0] DATA_RST = 10'h000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_BITS  = 2'b10,
        ST_STOP  = 2'b11
    } rx_state_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              frame_error_flag;
    } rx_word_t;

    localparam int unsigned WORD_W = DATA_W + 1;

endpackage : uart_rx_pkg

// *** hdl/rx_fifo.sv ***
/*
 * small flip-flop fifo with valid/ready on both sides.
 * assumes writer and reader are on the same clock.
 */
`timescale 1ns/10ps
module rx_fifo #(
    parameter int unsigned WIDTH = 11,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             i_mclk,    // system clock
    input  wire logic             i_rst_b,   // async reset, active low
    input  wire logic             i_valid,   // write request
    output logic                  o_ready,   // space available
    input  wire logic [WIDTH-1:0] i_data,    // write word
    output logic                  o_valid,   // word available
    input  wire logic             i_ready,   // reader takes word
    output logic [WIDTH-1:0]      o_data     // head word
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    // ------------------------------------------------------------
    // handshake
    // ------------------------------------------------------------
    assign o_ready = (cnt_r != (AW+1)'(DEPTH));
    assign o_valid = (cnt_r != '0);
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;
    assign o_data  = mem_r[rd_r];

    // storage; no reset needed since reads are gated by count
    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem_r[wr_r] <= i_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

endmodule : rx_fifo

// *** hdl/uart_async_rx_recovery.sv ***
/*
 * clock and data recovery of the asynchronous uart receiver, with a small
 * output fifo that holds each frame together with its frame error flag.
 * assumes the serial line is asynchronous and the divisor is static per frame.
 */
`timescale 1ns/10ps
module uart_async_rx_recovery
    import uart_rx_pkg::*;
(
    input  wire logic                     i_mclk,                // 250 MHz system clock
    input  wire logic                     i_rst_b,               // async reset, active low
    input  wire logic                     i_serial_rx_line,      // serial receive pin
    input  wire logic                     i_double_speed_select, // 1: 8 samples per bit
    input  wire logic [uart_rx_pkg::DIV_W-1:0] i_baud_divisor,   // sample tick every n+1
    input  wire logic [3:0]               i_frame_bits,          // data+parity, 5..10
    output logic                          o_valid,               // frame word available
    input  wire logic                     i_ready,               // consumer takes word
    output logic [uart_rx_pkg::DATA_W-1:0] o_data,               // received bits, lsb first
    output logic                          o_frame_error_flag,    // stop bit was zero
    output logic                          o_overrun              // frame lost, fifo full
);
    import uart_rx_pkg::*;

    // ------------------------------------------------------------
    // line synchroniser
    // ------------------------------------------------------------
    logic rx_meta_r;
    logic rx_sync_r;
    logic rx_prev_r;

    // first stage feeds only the second stage
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
        end else begin
            rx_meta_r <= i_serial_rx_line;
            rx_sync_r <= rx_meta_r;
        end
    end

    // ------------------------------------------------------------
    // sample tick divider
    // ------------------------------------------------------------
    logic [DIV_W-1:0] div_r;
    logic             tick;

    assign tick = (div_r == '0);

    // free running; one-cycle enable at the sample rate
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_r <= '0;
        end else if (tick) begin
            div_r <= i_baud_divisor;
        end else begin
            div_r <= div_r - 1'b1;
        end
    end

    // previous sample, for edge detection at the sample rate
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_prev_r <= 1'b1;
        end else if (tick) begin
            rx_prev_r <= rx_sync_r;
        end
    end

    // ------------------------------------------------------------
    // mode derived numbers
    // ------------------------------------------------------------
    logic       dbl;
    logic [3:0] last_samp;
    logic [3:0] vote_first;
    logic [3:0] vote_last;
    logic [3:0] rearm_samp;
    logic [3:0] nbits;

    assign dbl        = i_double_speed_select;
    assign last_samp  = dbl ? 4'(SAMP_DOUBLE - 1) : 4'(SAMP_NORMAL - 1);
    assign vote_first = dbl ? VOTE_D_FIRST : VOTE_N_FIRST;
    assign vote_last  = vote_first + 4'h2;
    // normal mode rearms on the last vote sample, so the very next sample may
    // already be the first low of a new start; double speed waits one more
    assign rearm_samp = dbl ? VOTE_D_REARM : vote_last;
    // clamp out-of-range lengths to the legal span
    assign nbits      = (i_frame_bits < BITS_MIN) ? BITS_MIN :
                        (i_frame_bits > BITS_MAX) ? BITS_MAX : i_frame_bits;

    // ------------------------------------------------------------
    // recovery state machine
    // ------------------------------------------------------------
    rx_state_t         state_r;
    logic [3:0]        samp_r;
    logic [3:0]        bit_r;
    logic [1:0]        ones_r;
    logic [DATA_W-1:0] shift_r;
    logic              vote_hit;
    logic              vote_end;
    logic              majority;
    logic [1:0]        ones_nxt;
    logic              fall;
    logic              done_pulse;
    logic              done_fe;

    // sample index counts from 1 at the first low sample
    assign vote_hit = (samp_r >= vote_first) && (samp_r <= vote_last);
    assign vote_end = (samp_r == vote_last);
    assign ones_nxt = ones_r + {1'b0, rx_sync_r};
    assign majority = ones_nxt[1];
    assign fall     = rx_prev_r && !rx_sync_r;

    // frame sequencing; all moves happen on sample ticks
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= ST_IDLE;
            samp_r  <= 4'h0;
            bit_r   <= 4'h0;
            ones_r  <= 2'h0;
            shift_r <= DATA_RST;
        end else if (tick) begin
            unique case (state_r)
                ST_IDLE: begin
                    ones_r <= 2'h0;
                    if (fall) begin
                        state_r <= ST_START;
                        samp_r  <= 4'h2;
                    end
                end
                ST_START: begin
                    samp_r <= samp_r + 4'h1;
                    if (vote_hit) begin
                        ones_r <= ones_nxt;
                    end
                    if (vote_end) begin
                        ones_r <= 2'h0;
                        if (majority) begin
                            state_r <= ST_IDLE;
                            samp_r  <= 4'h0;
                        end
                    end
                    if (samp_r == last_samp) begin
                        samp_r  <= 4'h0;
                        bit_r   <= 4'h0;
                        shift_r <= DATA_RST;
                        state_r <= ST_BITS;
                    end
                end
                ST_BITS: begin
                    samp_r <= (samp_r == last_samp) ? 4'h0 : samp_r + 4'h1;
                    if (vote_hit) begin
                        ones_r <= ones_nxt;
                    end
                    if (vote_end) begin
                        ones_r <= 2'h0;
                        shift_r[bit_r] <= majority;
                    end
                    if (samp_r == last_samp) begin
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == nbits - 4'h1) begin
                            state_r <= ST_STOP;
                        end
                    end
                end
                ST_STOP: begin
                    samp_r <= samp_r + 4'h1;
                    if (vote_hit) begin
                        ones_r <= ones_nxt;
                    end
                    if (samp_r == rearm_samp) begin
                        ones_r  <= 2'h0;
                        samp_r  <= 4'h0;
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // stop vote closes the frame; later stop bits are never looked at
    assign done_pulse = tick && (state_r == ST_STOP) && vote_end;
    assign done_fe    = !majority;

    // ------------------------------------------------------------
    // output buffer
    // ------------------------------------------------------------
    rx_word_t wr_word;
    rx_word_t rd_word;
    logic     fifo_ready;
    logic [WORD_W-1:0] rd_bits;

    // flag travels in the same word as its frame
    always_comb begin
        wr_word                  = '0;
        wr_word.data             = shift_r;
        wr_word.frame_error_flag = done_fe;
    end

    rx_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_mclk  (i_mclk),
        .i_rst_b (i_rst_b),
        .i_valid (done_pulse),
        .o_ready (fifo_ready),
        .i_data  (wr_word),
        .o_valid (o_valid),
        .i_ready (i_ready),
        .o_data  (rd_bits)
    );

    assign rd_word            = rx_word_t'(rd_bits);
    assign o_data             = rd_word.data;
    assign o_frame_error_flag = rd_word.frame_error_flag;

    // a serial source cannot stall, so a full buffer drops and reports it
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_overrun <= 1'b0;
        end else if (done_pulse) begin
            o_overrun <= !fifo_ready;
        end
    end

endmodule : uart_async_rx_recovery

// *** tb/uart_tx_model.sv ***
/* far-end transmitter model driving the serial line, idle high.
   assumes it shares the system clock; one sample is div+1 cycles. */
`timescale 1ns/10ps
module uart_tx_model (
    input  wire logic        i_mclk, // system clock
    input  wire logic [11:0] i_div,  // cycles per sample minus one
    output logic             o_line  // serial line
);
    initial o_line = 1'b1;
    // one bit of n samples; sample g is inverted to fake a spike
    task automatic bit_out(input logic v, input int n, input int g);
        for (int s = 0; s < n * (i_div + 1); s++) begin
            @(posedge i_mclk);
            o_line <= v ^ (s / (i_div + 1) == g);
        end
    endtask : bit_out
    // exact rate, so the receiver error budget is never touched
    task automatic send(input logic [9:0] d, input int nb, input int spb,
                        input int stop_n, input int g, input logic stop_v);
        bit_out(1'b0, spb, -1);
        for (int i = 0; i < nb; i++) begin
            bit_out(d[i], spb, g);
        end
        bit_out(stop_v, stop_n, -1);
        // a bad stop is followed by a second, good stop bit
        if (!stop_v) begin
            bit_out(1'b1, spb, -1);
        end
    endtask : send
endmodule : uart_tx_model

// *** tb/uart_rx_asserts.sv ***
/* port-level checker for the receive recovery block.
   assumes the divisor and frame size are static while words wait. */
`timescale 1ns/10ps
module uart_rx_asserts (
    input wire logic                          i_mclk,                // clock
    input wire logic                          i_rst_b,               // reset
    input wire logic                          i_serial_rx_line,      // line
    input wire logic                          i_double_speed_select, // mode
    input wire logic [uart_rx_pkg::DIV_W-1:0] i_baud_divisor,        // divisor
    input wire logic [3:0]                    i_frame_bits,          // size
    input wire logic                          o_valid,               // word ready
    input wire logic                          i_ready,               // pop
    input wire logic [uart_rx_pkg::DATA_W-1:0] o_data,               // word
    input wire logic                          o_frame_error_flag,    // stop was 0
    input wire logic                          o_overrun              // lost frame
);
    import uart_rx_pkg::*;
    int unsigned hi_run_r;
    int unsigned gap_r;
    int unsigned hi_lim;
    logic [3:0]  nb;
    // length of the current high run, saturated so it never wraps
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hi_run_r <= 0;
        end else if (!i_serial_rx_line) begin
            hi_run_r <= 0;
        end else if (hi_run_r < 100000) begin
            hi_run_r <= hi_run_r + 1;
        end
    end
    // cycles since the output last went non-empty
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gap_r <= 1000;
        end else if ($rose(o_valid)) begin
            gap_r <= 0;
        end else if (gap_r < 1000) begin
            gap_r <= gap_r + 1;
        end
    end
    // a whole frame is at most twelve bits long
    assign hi_lim = 12 * SAMP_NORMAL * (int'(i_baud_divisor) + 1) + 8;
    assign nb = (i_frame_bits < BITS_MIN) ? BITS_MIN :
                (i_frame_bits > BITS_MAX) ? BITS_MAX : i_frame_bits;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);
    sequence s_held;
        o_valid && !i_ready;
    endsequence
    sequence s_new_word;
        $rose(o_valid);
    endsequence
    a_reset_empty: assert property ($rose(i_rst_b) |-> !o_valid && !o_overrun)
        else $error("outputs not clear after reset");
    a_word_holds: assert property (s_held |=> o_valid)
        else $error("word vanished unpopped");
    a_word_stable: assert property (s_held |=> $stable(o_data) && $stable(o_frame_error_flag))
        else $error("word changed unpopped");
    a_upper_clear: assert property (o_valid |-> (o_data >> nb) == '0)
        else $error("bits beyond frame size set");
    a_idle_quiet: assert property (s_new_word |-> hi_run_r < hi_lim)
        else $error("word out of an idle line");
    a_frame_gap: assert property (s_new_word |-> gap_r >= 40)
        else $error("words closer than a frame");
    a_ovr_full: assert property ($rose(o_overrun) |-> $past(o_valid))
        else $error("overrun with buffer empty");
    a_ovr_clears: assert property ($fell(o_overrun) |-> ##[0:1] o_valid)
        else $error("overrun cleared without a word");
endmodule : uart_rx_asserts
bind uart_async_rx_recovery uart_rx_asserts uart_rx_asserts_inst (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_serial_rx_line(i_serial_rx_line),
    .i_double_speed_select(i_double_speed_select), .i_baud_divisor(i_baud_divisor),
    .i_frame_bits(i_frame_bits), .o_valid(o_valid), .i_ready(i_ready), .o_data(o_data),
    .o_frame_error_flag(o_frame_error_flag), .o_overrun(o_overrun));

// *** tb/tb.sv ***
/* self-checking bench for the receive recovery block.
   assumes the transmitter model runs on the same clock. */
`timescale 1ns/10ps
module tb;
    import uart_rx_pkg::*;
    logic              i_mclk = 1'b0;
    logic              i_rst_b = 1'b0;
    logic              dbl = 1'b0;
    logic              rdy = 1'b0;
    logic [DIV_W-1:0]  div = 12'h000;
    logic [3:0]        fbits = 4'h8;
    logic              line;
    logic [DATA_W-1:0] rx_data;
    logic              rx_valid, rx_fe, rx_ovr;
    int                err_count = 0;
    int                checked = 0;
    int                cyc = 0;
    always #2 i_mclk = ~i_mclk;
    uart_async_rx_recovery uart_async_rx_recovery_inst (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_serial_rx_line(line),
        .i_double_speed_select(dbl), .i_baud_divisor(div), .i_frame_bits(fbits),
        .o_valid(rx_valid), .i_ready(rdy), .o_data(rx_data),
        .o_frame_error_flag(rx_fe), .o_overrun(rx_ovr));
    uart_tx_model uart_tx_model_inst (.i_mclk(i_mclk), .i_div(div), .o_line(line));
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp,
                         input string what);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : check
    task automatic conclude();
        if (err_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude
    // the run should need about 6k cycles
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            conclude();
        end
    end
    // change config only while the line idles
    task automatic mode(input logic m, input logic [3:0] nb);
        @(posedge i_mclk);
        dbl <= m;
        div <= m ? 12'h001 : 12'h000;
        fbits <= nb;
        repeat (4) @(posedge i_mclk);
    endtask : mode
    // normal stop cut to 10 samples: next start lands right after the stop vote
    task automatic tx(input logic [9:0] d, input int g, input logic stop_v);
        uart_tx_model_inst.send(d, int'(fbits), dbl ? 8 : 16, dbl ? 8 : 10, g, stop_v);
    endtask : tx
    // wait for a word, judge it, then pop it with one ready cycle
    task automatic pop(input logic [9:0] d, input logic fe);
        int n;
        n = 0;
        while (rx_valid !== 1'b1 && n < 5000) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        check(DATA_W'(rx_valid), 10'h001, "no word arrived");
        check(rx_data, d & ~(10'h3FF << fbits), "data");
        check(DATA_W'(rx_fe), DATA_W'(fe), "frame error");
        @(posedge i_mclk);
        rdy <= 1'b1;
        @(posedge i_mclk);
        rdy <= 1'b0;
        #1;
    endtask : pop
    // every size in both modes, frames back to back
    task automatic t_modes();
        for (int m = 0; m < 2; m++) begin
            for (int nb = 5; nb <= 10; nb++) begin
                mode(m[0], nb[3:0]);
                tx(10'h2B5 ^ 10'(nb), -1, 1'b1);
                tx(10'h14A, -1, 1'b1);
                pop(10'h2B5 ^ 10'(nb), 1'b0);
                pop(10'h14A, 1'b0);
            end
        end
    endtask : t_modes
    // one inverted centre sample per bit is outvoted
    task automatic t_glitch();
        mode(1'b0, 4'h8);
        tx(10'h0A5, 8, 1'b1);
        pop(10'h0A5, 1'b0);
        mode(1'b1, 4'h8);
        tx(10'h05A, 4, 1'b1);
        pop(10'h05A, 1'b0);
    endtask : t_glitch
    // low spikes reaching only the first vote sample are rejected
    task automatic t_noise();
        for (int m = 0; m < 2; m++) begin
            mode(m[0], 4'h8);
            uart_tx_model_inst.bit_out(1'b0, m ? 4 : 8, -1);
            uart_tx_model_inst.bit_out(1'b1, 200, -1);
            check(DATA_W'(rx_valid), 10'h000, "spike gave a word");
            tx(10'h3C3, -1, 1'b1);
            pop(10'h3C3, 1'b0);
        end
    endtask : t_noise
    // zero first stop flags only its own frame
    task automatic t_ferr();
        mode(1'b0, 4'h8);
        tx(10'h081, -1, 1'b0);
        tx(10'h07E, -1, 1'b1);
        pop(10'h081, 1'b1);
        pop(10'h07E, 1'b0);
        mode(1'b1, 4'h7);
        tx(10'h055, -1, 1'b0);
        pop(10'h055, 1'b1);
    endtask : t_ferr
    // fifth frame into a full buffer is dropped
    task automatic t_overrun();
        mode(1'b0, 4'h5);
        for (int i = 0; i < 5; i++) begin
            tx(10'(i + 1), -1, 1'b1);
        end
        uart_tx_model_inst.bit_out(1'b1, 16, -1);
        check(DATA_W'(rx_ovr), 10'h001, "overrun not set");
        for (int i = 0; i < 4; i++) begin
            pop(10'(i + 1), 1'b0);
        end
        tx(10'h01F, -1, 1'b1);
        uart_tx_model_inst.bit_out(1'b1, 16, -1);
        check(DATA_W'(rx_ovr), 10'h000, "overrun not cleared");
        pop(10'h01F, 1'b0);
    endtask : t_overrun
    // reset for three cycles, then each scenario in turn
    initial begin
        repeat (3) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        repeat (4) @(posedge i_mclk);
        check(DATA_W'(rx_valid), 10'h000, "word after reset");
        t_modes();
        t_glitch();
        t_noise();
        t_ferr();
        t_overrun();
        conclude();
    end
endmodule : tb
